// File: verilog/tlaf_framer.sv
// Lane aggregation framer: interleaves client lanes into 66-bit aggregate
// frames with a multiframe marker, and splits received frames back out.
// Assumes clients and link logic share SYS_CLK_IN; only the link fail pin is
// asynchronous. One frame moves per cycle in each direction.
//
// Overview of operation
// - Aggregate frame carries 66 bits per 64 payload
// - Each client gets 64/N of 66 received bits
// - First multiframe frame carries marker in state field
// - Multiframe length is 202.5 frames times clients
// - Only lengths of the configured client count supported
// - Receiver uses configured length, no auto detection
// - Client count is a generic parameter
// - Clients frequency locked with bounded wander
// - Client bytes placed straight into payload, no stuffing
// - Optional transmit client underrun monitoring; here always on, with no switch
// - Link failure raises alarm toward clients
// - Per-lane buffer absorbs relative client wander
// - Marker encoded as state 011 or 001
// - Round-robin byte interleave, MSB first
// - Flag bits sent zero, ignored on receive
// - Lane 0 client frame start aligns with multiframe start
`timescale 1ns/100ps
`default_nettype none
module tlaf_framer #(
  parameter int N_CLIENTS = 2,
  parameter int LANE_W = 64 / N_CLIENTS,
  parameter int MF_LEN = tlaf_pkg::MF_FRAMES_X2_PER_CLIENT * N_CLIENTS / 2
) (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic [N_CLIENTS*LANE_W-1:0] TX_CLIENT_DATA_IN,
  input wire logic [N_CLIENTS-1:0] TX_CLIENT_START_IN,
  input wire logic [N_CLIENTS-1:0] TX_CLIENT_VALID_IN,
  output logic [N_CLIENTS-1:0] TX_CLIENT_READY_OUT,
  input wire logic TX_LINK_READY_IN,
  output logic TX_FRAME_VALID_OUT,
  output logic [63:0] TX_PAYLOAD_OUT,
  output logic [1:0] TX_TFLAG_OUT,
  output logic [2:0] TX_STATE_OUT,
  output logic [N_CLIENTS-1:0] TX_CLIENT_FAULT_OUT,
  input wire logic RX_FRAME_VALID_IN,
  input wire logic [63:0] RX_PAYLOAD_IN,
  input wire logic [1:0] RX_TFLAG_IN,
  input wire logic [2:0] RX_STATE_IN,
  input wire logic RX_LINK_FAIL_IN,
  output logic RX_CLIENT_VALID_OUT,
  output logic [N_CLIENTS*LANE_W-1:0] RX_CLIENT_DATA_OUT,
  output logic RX_CLIENT_START_OUT,
  output logic RX_IN_SYNC_OUT,
  output logic RX_ALARM_OUT
);

  // ----------------------------------------------------------------
  // Derived constants
  // ----------------------------------------------------------------
  localparam int CW = tlaf_pkg::CNT_W;
  localparam int DEPTH = tlaf_pkg::WANDER_DEPTH;
  localparam int AW = $clog2(DEPTH);
  localparam int BYTES_PER_LANE = LANE_W / 8;
  localparam logic [CW-1:0] MF_LAST = CW'(MF_LEN - 1);
  localparam logic [AW:0] FILL_LVL = (AW+1)'(tlaf_pkg::WANDER_FILL_START);

  typedef enum logic [0:0] {TLAF_FILL, TLAF_RUN} tlaf_tx_state_e;

  // ----------------------------------------------------------------
  // Byte interleave helpers
  // ----------------------------------------------------------------
  // Payload byte k (k=0 on the first sent bit) belongs to lane k mod N
  function automatic logic [63:0] tlaf_interleave(input logic [N_CLIENTS*LANE_W-1:0] lanes);
    logic [63:0] p;
    p = '0;
    for (int k = 0; k < 8; k++) begin
      p[63-8*k -: 8] = lanes[(k % N_CLIENTS)*LANE_W + LANE_W - 1 - 8*(k / N_CLIENTS) -: 8];
    end
    return p;
  endfunction

  function automatic logic [N_CLIENTS*LANE_W-1:0] tlaf_deinterleave(input logic [63:0] p);
    logic [N_CLIENTS*LANE_W-1:0] lanes;
    lanes = '0;
    for (int k = 0; k < 8; k++) begin
      lanes[(k % N_CLIENTS)*LANE_W + LANE_W - 1 - 8*(k / N_CLIENTS) -: 8] = p[63-8*k -: 8];
    end
    return lanes;
  endfunction

  // ----------------------------------------------------------------
  // Transmit wander buffers
  // ----------------------------------------------------------------
  logic [LANE_W:0] lane_head [N_CLIENTS];
  logic [AW:0] lane_level [N_CLIENTS];
  logic [N_CLIENTS-1:0] lane_valid;
  logic pop_frame;

  genvar g;
  generate
    for (g = 0; g < N_CLIENTS; g++) begin : gen_lane
      // Depth bounds the wander tolerated; beyond it a lane underruns
      tlaf_wander_fifo #(
        .WIDTH(LANE_W + 1),
        .DEPTH(DEPTH)
      ) u_fifo (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(NRST_IN),
        .wr_valid_in(TX_CLIENT_VALID_IN[g]),
        .wr_data_in({TX_CLIENT_START_IN[g], TX_CLIENT_DATA_IN[g*LANE_W +: LANE_W]}),
        .wr_ready_out(TX_CLIENT_READY_OUT[g]),
        .rd_valid_out(lane_valid[g]),
        .rd_data_out(lane_head[g]),
        .rd_ready_in(pop_frame),
        .level_out(lane_level[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Transmit framing
  // ----------------------------------------------------------------
  tlaf_tx_state_e tx_state, next_tx_state;
  logic [CW-1:0] tx_cnt, next_tx_cnt;
  logic tx_valid, next_tx_valid;
  logic [63:0] tx_payload, next_tx_payload;
  logic [2:0] tx_mark, next_tx_mark;
  logic [N_CLIENTS-1:0] tx_fault, next_tx_fault;
  logic [1:0] tx_tflag, next_tx_tflag;
  logic all_filled;
  logic mark_now;
  logic [N_CLIENTS*LANE_W-1:0] lane_words;

  always_comb begin
    all_filled = 1'b1;
    lane_words = '0;
    for (int i = 0; i < N_CLIENTS; i++) begin
      if (lane_level[i] < FILL_LVL) begin
        all_filled = 1'b0;
      end
      // An empty lane sends zeros rather than slipping its neighbours
      if (lane_valid[i]) begin
        lane_words[i*LANE_W +: LANE_W] = lane_head[i][LANE_W-1:0];
      end
    end
    next_tx_state = tx_state;
    next_tx_cnt = tx_cnt;
    next_tx_valid = 1'b0;
    next_tx_payload = tx_payload;
    next_tx_mark = tx_mark;
    next_tx_fault = tx_fault;
    next_tx_tflag = tlaf_pkg::TFLAG_TX_VALUE;
    pop_frame = 1'b0;
    mark_now = 1'b0;
    case (tx_state)
      TLAF_FILL: begin
        if (all_filled) begin
          next_tx_state = TLAF_RUN;
        end
      end
      TLAF_RUN: begin
        pop_frame = TX_LINK_READY_IN;
        if (pop_frame) begin
          // Lane 0 carrying its client frame start forces a multiframe start
          mark_now = (tx_cnt == '0) || (lane_valid[0] && lane_head[0][LANE_W]);
          next_tx_valid = 1'b1;
          next_tx_payload = tlaf_interleave(lane_words);
          next_tx_mark = mark_now ? tlaf_pkg::STATE_MF_MARK : tlaf_pkg::STATE_PLAIN;
          next_tx_cnt = mark_now ? CW'(1) : ((tx_cnt == MF_LAST) ? '0 : tx_cnt + 1'b1);
          next_tx_fault = ~lane_valid;
          if (MF_LAST == '0) begin
            next_tx_cnt = '0;
          end
        end
      end
      default: begin
        next_tx_state = TLAF_FILL;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      tx_state <= TLAF_FILL;
      tx_cnt <= '0;
      tx_valid <= 1'b0;
      tx_payload <= '0;
      tx_mark <= tlaf_pkg::STATE_PLAIN;
      tx_fault <= '0;
      tx_tflag <= tlaf_pkg::TFLAG_TX_VALUE;
    end else begin
      tx_state <= next_tx_state;
      tx_cnt <= next_tx_cnt;
      tx_valid <= next_tx_valid;
      tx_payload <= next_tx_payload;
      tx_mark <= next_tx_mark;
      tx_fault <= next_tx_fault;
      tx_tflag <= next_tx_tflag;
    end
  end

  // One 66-bit frame carries 64 payload bits, shared by N lanes
  assign TX_FRAME_VALID_OUT = tx_valid;
  assign TX_PAYLOAD_OUT = tx_payload;
  assign TX_TFLAG_OUT = tx_tflag;
  assign TX_STATE_OUT = tx_mark;
  assign TX_CLIENT_FAULT_OUT = tx_fault;

  // ----------------------------------------------------------------
  // Receive de-framing
  // ----------------------------------------------------------------
  logic fail_meta, fail_sync;
  logic [CW-1:0] rx_cnt, next_rx_cnt;
  logic rx_sync, next_rx_sync;
  logic rx_valid, next_rx_valid;
  logic rx_start, next_rx_start;
  logic rx_alarm, next_rx_alarm;
  logic [N_CLIENTS*LANE_W-1:0] rx_data, next_rx_data;
  logic rx_marker;

  always_comb begin
    // Flag bits are not looked at; only payload and state matter
    rx_marker = (RX_STATE_IN == tlaf_pkg::STATE_MF_MARK) ||
                (RX_STATE_IN == tlaf_pkg::STATE_MF_MARK_ALT);
    next_rx_cnt = rx_cnt;
    next_rx_sync = rx_sync;
    next_rx_valid = RX_FRAME_VALID_IN;
    next_rx_start = 1'b0;
    next_rx_data = rx_data;
    if (RX_FRAME_VALID_IN) begin
      next_rx_data = tlaf_deinterleave(RX_PAYLOAD_IN);
      if (rx_marker) begin
        next_rx_cnt = (MF_LAST == '0) ? '0 : CW'(1);
        next_rx_sync = 1'b1;
        next_rx_start = 1'b1;
      end else begin
        next_rx_cnt = (rx_cnt == MF_LAST) ? '0 : rx_cnt + 1'b1;
        // A multiframe boundary with no marker means lost alignment
        if (rx_cnt == '0) begin
          next_rx_sync = 1'b0;
        end
      end
    end
    next_rx_alarm = !next_rx_sync || fail_sync;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      fail_meta <= 1'b0;
      fail_sync <= 1'b0;
      rx_cnt <= '0;
      rx_sync <= 1'b0;
      rx_valid <= 1'b0;
      rx_start <= 1'b0;
      rx_alarm <= 1'b1;
      rx_data <= '0;
    end else begin
      fail_meta <= RX_LINK_FAIL_IN;
      fail_sync <= fail_meta;
      rx_cnt <= next_rx_cnt;
      rx_sync <= next_rx_sync;
      rx_valid <= next_rx_valid;
      rx_start <= next_rx_start;
      rx_alarm <= next_rx_alarm;
      rx_data <= next_rx_data;
    end
  end

  assign RX_CLIENT_VALID_OUT = rx_valid;
  assign RX_CLIENT_DATA_OUT = rx_data;
  assign RX_CLIENT_START_OUT = rx_start;
  assign RX_IN_SYNC_OUT = rx_sync;
  assign RX_ALARM_OUT = rx_alarm;

endmodule
`default_nettype wire

// File: verilog/tlaf_pkg.sv
// Shared constants of the lane aggregation framer: frame layout, state codes,
// multiframe sizing and wander buffer sizing.
// Assumes a 66-bit frame of 64 payload bits and two overhead flag bits.
package tlaf_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int PAYLOAD_BITS = 64;
  localparam int TFLAG_BITS = 2;
  localparam int FRAME_BITS = 66;
  localparam int STATE_W = 3;
  // Overhead factor 1.03125 written as a ratio
  localparam int OVH_NUM = 33;
  localparam int OVH_DEN = 32;
  localparam logic [1:0] TFLAG_TX_VALUE = 2'b00;

  // ----------------------------------------------------------------
  // State field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] STATE_MF_MARK = 3'b011;
  localparam logic [2:0] STATE_MF_MARK_ALT = 3'b001;
  localparam logic [2:0] STATE_PLAIN = 3'b000;

  // ----------------------------------------------------------------
  // Multiframe sizing
  // ----------------------------------------------------------------
  // 202.5 frames per 2.48832 Gb/s client, kept doubled to stay integral
  localparam int MF_FRAMES_X2_PER_CLIENT = 405;
  localparam int CNT_W = 12;

  // ----------------------------------------------------------------
  // Wander buffer
  // ----------------------------------------------------------------
  localparam int WANDER_DEPTH = 4;
  localparam int WANDER_FILL_START = 2;

endpackage

// File: verilog/tlaf_wander_fifo.sv
// Small per-lane elastic store of client words.
// Assumes both sides on one clock; DEPTH is a power of two.
`timescale 1ns/100ps
`default_nettype none
module tlaf_wander_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 4,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_valid_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic wr_ready_out,
  output logic rd_valid_out,
  output logic [WIDTH-1:0] rd_data_out,
  input wire logic rd_ready_in,
  output logic [AW:0] level_out
);

  localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic not_full, next_not_full;
  logic do_wr, do_rd;

  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    do_wr = wr_valid_in && (count != FULL_LVL);
    do_rd = rd_ready_in && (count != '0);
    if (do_wr) begin
      next_mem[wr_ptr] = wr_data_in;
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (do_rd) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
    if (do_wr && !do_rd) begin
      next_count = count + 1'b1;
    end else if (do_rd && !do_wr) begin
      next_count = count - 1'b1;
    end
    next_not_full = (next_count != FULL_LVL);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      not_full <= 1'b1;
    end else begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      not_full <= next_not_full;
    end
  end

  assign wr_ready_out = not_full;
  assign rd_valid_out = (count != '0);
  assign rd_data_out = mem[rd_ptr];
  assign level_out = count;

endmodule
`default_nettype wire

// File: verification/tlaf_framer_properties.sv
// Port checker for tlaf_framer.
// Assumes one clock and a sync active-low reset.
`timescale 1ns/100ps
`default_nettype none
module tlaf_framer_properties #(
  parameter int N_CLIENTS = 2,
  parameter int MF_LEN = 405
) (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic TX_LINK_READY_IN,
  input wire logic TX_FRAME_VALID_OUT,
  input wire logic [1:0] TX_TFLAG_OUT,
  input wire logic [2:0] TX_STATE_OUT,
  input wire logic RX_FRAME_VALID_IN,
  input wire logic [63:0] RX_PAYLOAD_IN,
  input wire logic [2:0] RX_STATE_IN,
  input wire logic RX_LINK_FAIL_IN,
  input wire logic RX_CLIENT_VALID_OUT,
  input wire logic [63:0] RX_CLIENT_DATA_OUT,
  input wire logic RX_CLIENT_START_OUT,
  input wire logic RX_IN_SYNC_OUT,
  input wire logic RX_ALARM_OUT
);
  localparam int LW = 64 / N_CLIENTS;
  logic [63:0] dei;
  logic [11:0] gap;
  always_comb begin
    dei = '0;
    for (int k = 0; k < 8; k++) begin
      dei[(k%N_CLIENTS)*LW+LW-1-8*(k/N_CLIENTS) -: 8] = RX_PAYLOAD_IN[63-8*k -: 8];
    end
  end
  // Frames since last marker; zero only before the first frame
  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      gap <= 12'h0;
    end else if (TX_FRAME_VALID_OUT) begin
      gap <= (TX_STATE_OUT == 3'h3) ? 12'h1 : gap + 12'h1;
    end
  end
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  sequence s_fail_held;
    RX_LINK_FAIL_IN [*4];
  endsequence
  sequence s_rx_mark;
    RX_FRAME_VALID_IN && (RX_STATE_IN == 3'h3 || RX_STATE_IN == 3'h1);
  endsequence
  a_tflag_zero: assert property (TX_TFLAG_OUT == 2'h0)
    else $error("flag bits not zero");
  a_frame_cause: assert property (TX_FRAME_VALID_OUT |-> $past(TX_LINK_READY_IN))
    else $error("frame without link ready");
  a_state_code: assert property (TX_FRAME_VALID_OUT |-> TX_STATE_OUT inside {3'h0, 3'h3})
    else $error("bad state code");
  a_mark_gap: assert property (TX_FRAME_VALID_OUT |->
    (TX_STATE_OUT == 3'h3) == (gap == 0 || gap == MF_LEN))
    else $error("marker spacing wrong");
  a_rx_answer: assert property (RX_FRAME_VALID_IN |=> RX_CLIENT_VALID_OUT)
    else $error("rx valid missing");
  a_rx_data: assert property (RX_FRAME_VALID_IN |=> RX_CLIENT_DATA_OUT == $past(dei))
    else $error("rx deinterleave wrong");
  a_rx_mark: assert property (s_rx_mark |=> RX_CLIENT_START_OUT && RX_IN_SYNC_OUT)
    else $error("marker not followed");
  a_alarm_fail: assert property (s_fail_held |-> RX_ALARM_OUT)
    else $error("alarm not raised");
endmodule
bind tlaf_framer tlaf_framer_properties #(.N_CLIENTS(N_CLIENTS), .MF_LEN(MF_LEN)) u_props (
  .SYS_CLK_IN(SYS_CLK_IN), .NRST_IN(NRST_IN), .TX_LINK_READY_IN(TX_LINK_READY_IN),
  .TX_FRAME_VALID_OUT(TX_FRAME_VALID_OUT), .TX_TFLAG_OUT(TX_TFLAG_OUT),
  .TX_STATE_OUT(TX_STATE_OUT), .RX_FRAME_VALID_IN(RX_FRAME_VALID_IN),
  .RX_PAYLOAD_IN(RX_PAYLOAD_IN), .RX_STATE_IN(RX_STATE_IN), .RX_LINK_FAIL_IN(RX_LINK_FAIL_IN),
  .RX_CLIENT_VALID_OUT(RX_CLIENT_VALID_OUT), .RX_CLIENT_DATA_OUT(RX_CLIENT_DATA_OUT),
  .RX_CLIENT_START_OUT(RX_CLIENT_START_OUT), .RX_IN_SYNC_OUT(RX_IN_SYNC_OUT),
  .RX_ALARM_OUT(RX_ALARM_OUT)
);
`default_nettype wire

// File: verification/tlaf_link_model.sv
// Link partner: echoes each tx frame on the rx side one cycle later.
// Assumes the same clock as the framer.
`timescale 1ns/100ps
`default_nettype none
module tlaf_link_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic alt_in,
  input wire logic tx_valid_in,
  input wire logic [63:0] tx_payload_in,
  input wire logic [2:0] tx_state_in,
  output logic ready_out,
  output logic rx_valid_out,
  output logic [63:0] rx_payload_out,
  output logic [1:0] rx_tflag_out,
  output logic [2:0] rx_state_out
);
  logic tog = 1'b0;
  initial begin
    rx_valid_out = 1'b0;
    rx_payload_out = '0;
    rx_tflag_out = 2'h0;
    rx_state_out = 3'h0;
  end
  // Slow mode takes a frame every other cycle
  assign ready_out = !slow_in || tog;
  // Shared clock keeps link and clients locked
  always @(posedge clk_in) begin
    tog <= #1 !tog;
    rx_valid_out <= #1 tx_valid_in;
    if (tx_valid_in) begin
      rx_payload_out <= #1 tx_payload_in;
      rx_state_out <= #1 (alt_in && tx_state_in == 3'h3) ? 3'h1 : tx_state_in;
      rx_tflag_out <= #1 {2{alt_in}};
    end else begin
      // Idle payload and state lines toggle so stale data never looks valid
      rx_payload_out <= #1 ~rx_payload_out;
      rx_state_out <= #1 ~rx_state_out;
    end
  end
endmodule
`default_nettype wire

// File: verification/tb_tlaf_framer.sv
// Self-checking bench for tlaf_framer with two clients.
// Assumes tlaf_link_model loops tx frames back to rx.
`timescale 1ns/100ps
`default_nettype none
module tb_tlaf_framer;
  localparam int N = 2;
  localparam int LW = 64 / N;
  localparam int MF = 405;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic fail = 1'b0;
  logic slow = 1'b0;
  logic alt = 1'b0;
  logic [N-1:0] feed = '1;
  logic [N-1:0] cvalid = '0;
  logic [N-1:0] cstart = '0;
  logic [63:0] cdata = '0;
  logic [N-1:0] cready, fault;
  logic lready, tvalid, rvalid, cvld, cst, insync, alarm;
  logic [63:0] tpay, rpay, rdata;
  logic [1:0] tflag, rflag;
  logic [2:0] tstate, rstate;
  logic [LW-1:0] q[N][$];
  logic [64:0] rq[$];
  int sq[N] = '{default: 0};
  int err_total = 0;
  int n_tests = 0;
  int nfr = 0;
  tlaf_framer #(.N_CLIENTS(N)) u_dut (
    .SYS_CLK_IN(clk), .NRST_IN(nrst), .TX_CLIENT_DATA_IN(cdata),
    .TX_CLIENT_START_IN(cstart), .TX_CLIENT_VALID_IN(cvalid), .TX_CLIENT_READY_OUT(cready),
    .TX_LINK_READY_IN(lready), .TX_FRAME_VALID_OUT(tvalid), .TX_PAYLOAD_OUT(tpay),
    .TX_TFLAG_OUT(tflag), .TX_STATE_OUT(tstate), .TX_CLIENT_FAULT_OUT(fault),
    .RX_FRAME_VALID_IN(rvalid), .RX_PAYLOAD_IN(rpay), .RX_TFLAG_IN(rflag),
    .RX_STATE_IN(rstate), .RX_LINK_FAIL_IN(fail), .RX_CLIENT_VALID_OUT(cvld),
    .RX_CLIENT_DATA_OUT(rdata), .RX_CLIENT_START_OUT(cst), .RX_IN_SYNC_OUT(insync),
    .RX_ALARM_OUT(alarm)
  );
  tlaf_link_model u_link (
    .clk_in(clk), .slow_in(slow), .alt_in(alt), .tx_valid_in(tvalid),
    .tx_payload_in(tpay), .tx_state_in(tstate), .ready_out(lready), .rx_valid_out(rvalid),
    .rx_payload_out(rpay), .rx_tflag_out(rflag), .rx_state_out(rstate)
  );
  always #2 clk = ~clk;
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Feed below three words so a late ready never drops a word
  always @(posedge clk) begin
    #1;
    for (int i = 0; i < N; i++) begin
      cvalid[i] = nrst && feed[i] && cready[i] && q[i].size() < 3;
      cdata[i*LW +: LW] = LW'(sq[i] * 16 + i);
      cstart[i] = sq[i] % MF == 0;
      if (cvalid[i]) begin
        q[i].push_back(cdata[i*LW +: LW]);
        sq[i]++;
      end
    end
  end
  always @(posedge clk) begin
    logic [63:0] w;
    logic [63:0] e;
    logic [N-1:0] f;
    if (tvalid) begin
      for (int i = 0; i < N; i++) begin
        f[i] = q[i].size() == 0;
        w[i*LW +: LW] = f[i] ? '0 : q[i].pop_front();
      end
      for (int k = 0; k < 8; k++) begin
        e[63-8*k -: 8] = w[(k%N)*LW+LW-1-8*(k/N) -: 8];
      end
      chk("payload", tpay, e);
      chk("state", tstate, nfr % MF == 0 ? 3'h3 : 3'h0);
      chk("tflag", tflag, 2'h0);
      chk("fault", fault, f);
      rq.push_back({tstate == 3'h3, w});
      nfr++;
    end
  end
  always @(posedge clk) begin
    logic [64:0] x;
    if (cvld) begin
      x = rq.pop_front();
      chk("rx data", rdata, x[63:0]);
      chk("rx start", cst, x[64]);
      chk("in sync", insync, 1'b1);
    end
  end
  task automatic wait_frames(input int n);
    int t;
    t = nfr + n;
    for (int c = 0; c < 3 * n + 50 && nfr < t; c++) begin
      @(posedge clk);
    end
    #1;
    chk("frames", nfr >= t, 1'b1);
  endtask
  task automatic t_stream();
    wait_frames(MF + 3);
    chk("alarm", alarm, 1'b0);
  endtask
  task automatic t_slow();
    slow = 1'b1;
    wait_frames(40);
    slow = 1'b0;
  endtask
  task automatic t_alt();
    alt = 1'b1;
    wait_frames(MF - nfr % MF + 2);
    chk("alt sync", insync, 1'b1);
    alt = 1'b0;
  endtask
  task automatic t_underrun();
    feed[1] = 1'b0;
    wait_frames(8);
    chk("underrun", fault[1], 1'b1);
  endtask
  task automatic t_fail();
    fail = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("fail alarm", alarm, 1'b1);
    fail = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("alarm clear", alarm, 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1;
    chk("reset alarm", alarm, 1'b1);
    chk("reset sync", insync, 1'b0);
    chk("reset ready", cready == '1, 1'b1);
    chk("reset valid", {tvalid, cvld, fault}, 4'h0);
    nrst <= 1'b1;
    t_stream();
    t_slow();
    t_alt();
    t_underrun();
    t_fail();
    print_verdict();
  end
  initial begin
    #20000;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
